// [common/bcdb_pkg.sv]
// Shared constants and types for the capability descriptor builder
package bcdb_pkg;

    // Descriptor header bytes, forced by hardware
    localparam logic [7:0] USB2_LEN = 8'h07;
    localparam logic [7:0] CAP_DESC_TYPE = 8'h10;
    localparam logic [7:0] USB2_CAP_TYPE = 8'h02;
    localparam logic [7:0] SS_LEN = 8'h0A;
    localparam logic [7:0] SS_CAP_TYPE = 8'h03;

    // Attribute defaults, kept-bit masks and forced-one masks
    localparam logic [31:0] USB2_ATTR_DEF = 32'h00000006;
    localparam logic [31:0] USB2_ATTR_KEEP = 32'h0000FF1E;
    localparam logic [31:0] USB2_ATTR_SET = 32'h00000002;
    localparam logic [7:0] SS_ATTR_DEF = 8'h00;
    localparam logic [7:0] SS_ATTR_KEEP = 8'h02;
    localparam logic [7:0] SS_ATTR_SET = 8'h00;
    localparam logic [15:0] SPEEDS_DEF = 16'h000E;
    localparam logic [15:0] SPEEDS_KEEP = 16'h000F;
    localparam logic [15:0] SPEEDS_SET = 16'h0000;

    // Byte offsets inside the descriptors
    localparam logic [3:0] OFF_LEN = 4'h0;
    localparam logic [3:0] OFF_TYPE = 4'h1;
    localparam logic [3:0] OFF_CAP = 4'h2;
    localparam logic [3:0] OFF_ATTR = 4'h3;
    localparam logic [3:0] OFF_SPEEDS = 4'h4;
    localparam logic [3:0] OFF_SPEEDS_HI = 4'h5;
    localparam logic [3:0] OFF_ATTR_TOP = 4'h6;

    // Attribute bit positions
    localparam int ATTR_LPM_BIT = 1;
    localparam int ATTR_ALT_BIT = 2;
    localparam int ATTR_BASE_VALID_BIT = 3;
    localparam int ATTR_DEEP_VALID_BIT = 4;

    // Register map (byte addresses)
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_USB2_ATTR = 8'h08;
    localparam logic [7:0] REG_SS_CAP = 8'h0C;
    localparam int CTRL_USE_DEF_BIT = 0;
    localparam int CTRL_REBUILD_BIT = 1;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_FROM_STORE_BIT = 1;
    localparam int STAT_LPM_MISMATCH_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int SS_CAP_SPEEDS_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Descriptor selector on the read port
    localparam logic SEL_USB2 = 1'b0;
    localparam logic SEL_SS = 1'b1;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_BUILD = 3'b010,
        ST_READY = 3'b100
    } bcdb_state_t;

    // Image of the configuration store as presented by the loader
    typedef struct packed {
        logic present;
        logic [31:0] usb2_attr;
        logic [7:0] ss_attr;
        logic [15:0] ss_speeds;
    } bcdb_store_t;

    typedef struct packed {
        logic valid;
        logic sel;
        logic [3:0] off;
    } bcdb_desc_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } bcdb_desc_ans_t;

endpackage

// [verif/bcdb_builder_test.sv]
// Self-checking bench for the capability descriptor builder
`timescale 1ns/1ps
`default_nettype none
module bcdb_builder_test;
    import bcdb_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic cfg_load_done = 1'b0;
    logic flag = 1'b1;
    logic go = 1'b0;
    logic hsel = 1'b0;
    logic busy;
    logic [3:0] lat_deep;
    logic [3:0] lat_base;
    bcdb_store_t st = '0;
    bcdb_desc_req_t req;
    bcdb_desc_ans_t ans;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] exp_u2 = 32'h00000000;
    logic [7:0] exp_ss = 8'h00;
    logic [15:0] exp_sp = 16'h0000;
    logic [31:0] exp_st = 32'h00000000;
    logic exp_rdy = 1'b0;
    logic [8:0] q_d[$];
    logic [33:0] q_b[$];
    int err_total = 0;
    int n_tests = 0;

    bcdb_builder bcdb_builder_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .cfg_load_done(cfg_load_done),
        .store_i(st), .link_power_mgmt_capable_flag(flag), .desc_req_i(req),
        .desc_ans_o(ans), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    bcdb_host_model bcdb_host_model_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .go(go), .sel(hsel), .ans(ans),
        .req(req), .busy(busy), .lat_deep(lat_deep), .lat_base(lat_base)
    );

    always #12.5 aclk = ~aclk;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Expected {err, data} for one descriptor byte, byte 0 at the bottom
    function automatic logic [8:0] exp_byte(input logic s, input logic [3:0] o);
        logic [55:0] u;
        logic [47:0] v;
        u = {exp_u2, 8'h02, 8'h10, 8'h07};
        v = {exp_sp, exp_ss, 8'h03, 8'h10, 8'h0A};
        if (!exp_rdy || o >= (s ? 4'hA : 4'h7)) return 9'h100;
        if (!s) return {1'b0, u[8 * o +: 8]};
        return (o > 4'h5) ? 9'h000 : {1'b0, v[8 * o +: 8]};
    endfunction

    task automatic expect_build(input logic use_def);
        logic us;
        us = st.present & ~use_def;
        exp_u2 = us ? ((st.usb2_attr & 32'h0000FF1E) | 32'h00000002) : 32'h00000006;
        exp_ss = us ? (st.ss_attr & 8'h02) : 8'h00;
        exp_sp = us ? (st.ss_speeds & 16'h000F) : 16'h000E;
        exp_st = {28'h0, 1'b0, us & (st.usb2_attr[1] != flag), us, 1'b1};
        exp_rdy = 1'b1;
    endtask

    // Notes each expected answer as requests are taken, compares as answers land
    always @(posedge aclk) begin
        if (aresetn && ce && req.valid) q_d.push_back(exp_byte(req.sel, req.off));
        if (aresetn && ce && ans.valid) begin
            if (q_d.size() == 0) check({25'h0, ans.err, ans.data}, 34'h3FFFFFFFF);
            else check({25'h0, ans.err, ans.data}, {25'h0, q_d.pop_front()});
        end
        if (ce && bvalid && bready) check({bresp, 32'h0}, q_b.pop_front());
        if (ce && rvalid && rready) check({rresp, rdata}, q_b.pop_front());
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        q_b.push_back({er, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        q_b.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // One full descriptor walk, optionally with the clock enable stuttering
    task automatic host_read(input logic s, input logic rc);
        go <= 1'b1;
        hsel <= s;
        ce <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do begin
            @(posedge aclk);
            // Only stutter while the walk is still running, so ce is set once per step
            if (rc && busy) ce <= 1'($urandom_range(1, 0));
        end while (busy);
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        final_report();
    end

    initial begin
        void'($urandom(32'h54D8B89C));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(REG_STATUS, 32'h00000000, RESP_OKAY);
        host_read(SEL_USB2, 1'b0);
        // Empty store: everything comes from the defaults
        cfg_load_done <= 1'b1;
        repeat (4) @(posedge aclk);
        expect_build(1'b0);
        host_read(SEL_USB2, 1'b0);
        host_read(SEL_SS, 1'b0);
        axi_rd(REG_STATUS, exp_st, RESP_OKAY);
        // Random stored images; the last pass disagrees with the config flag
        for (int i = 0; i < 6; i++) begin
            cfg_load_done <= 1'b0;
            st <= '{1'b1, $urandom, 8'($urandom), 16'($urandom)};
            @(posedge aclk);
            flag <= st.usb2_attr[1] ^ (i == 5);
            cfg_load_done <= 1'b1;
            @(posedge aclk);
            axi_wr(REG_CTRL, 32'h00000002, RESP_OKAY);
            repeat (4) @(posedge aclk);
            expect_build(1'b0);
            host_read(SEL_USB2, i[0]);
            check({26'h0, lat_deep, lat_base}, {26'h0, exp_u2[4] ? exp_u2[15:12] : 4'h0,
                exp_u2[3] ? exp_u2[11:8] : 4'h0});
            host_read(SEL_SS, ~i[0]);
            axi_rd(REG_STATUS, exp_st, RESP_OKAY);
            axi_rd(REG_USB2_ATTR, exp_u2, RESP_OKAY);
            axi_rd(REG_SS_CAP, {8'h00, exp_sp, exp_ss}, RESP_OKAY);
        end
        // Defaults forced by software although the store is present
        axi_wr(REG_CTRL, 32'h00000001, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h00000003, RESP_OKAY);
        repeat (4) @(posedge aclk);
        expect_build(1'b1);
        axi_rd(REG_CTRL, 32'h00000001, RESP_OKAY);
        host_read(SEL_USB2, 1'b1);
        host_read(SEL_SS, 1'b0);
        axi_rd(REG_STATUS, exp_st, RESP_OKAY);
        // Unmapped and read-only places
        axi_wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
        axi_wr(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
        axi_rd(8'h20, 32'h00000000, RESP_SLVERR);
        axi_rd(REG_STATUS, exp_st, RESP_OKAY);
        final_report();
    end
endmodule // bcdb_builder_test
`default_nettype wire

// [verif/bcdb_host_model.sv]
// Host-side reader that walks the capability descriptors byte by byte
`timescale 1ns/1ps
`default_nettype none
module bcdb_host_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic go,
    input wire logic sel,
    input wire bcdb_pkg::bcdb_desc_ans_t ans,
    output bcdb_pkg::bcdb_desc_req_t req,
    output logic busy,
    output logic [3:0] lat_deep,
    output logic [3:0] lat_base
);
    import bcdb_pkg::*;
    logic [3:0] off_q;
    logic sel_q;
    logic [31:0] word_q;

    // Offsets 0..11 run past the end of both descriptors on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req <= '0;
        end else if (ce) begin
            if (go) begin
                req <= '{valid: 1'b1, sel: sel, off: 4'h0};
            end else if (req.valid && req.off == 4'hB) begin
                req.valid <= 1'b0;
            end else if (req.valid) begin
                req.off <= req.off + 4'h1;
            end else begin
                // Idle selector and offset keep moving so stale values never look valid
                req.off <= req.off + 4'h5;
                req.sel <= ~req.sel;
            end
        end
    end

    // Attribute bytes arrive low byte first and are packed into one word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_q <= 4'h0;
            sel_q <= 1'b0;
            word_q <= 32'h00000000;
        end else if (ce) begin
            off_q <= req.off;
            sel_q <= req.sel;
            if (ans.valid && !ans.err && !sel_q && off_q >= 4'h3 && off_q <= 4'h6) begin
                word_q[8 * (off_q - 4'h3) +: 8] <= ans.data;
            end
        end
    end

    // Latency values count only when their valid flag is set
    assign busy = req.valid;
    assign lat_deep = word_q[4] ? word_q[15:12] : 4'h0;
    assign lat_base = word_q[3] ? word_q[11:8] : 4'h0;
endmodule // bcdb_host_model
`default_nettype wire

// [verilog/bcdb_builder.sv]
// Builds the USB 2.0 extension and SuperSpeed capability descriptors
// Summary of operation
// [R1] USB 2.0 extension filled from store or defaults
// [R2] Force USB 2.0 header bytes 07h/10h/02h
// [R3] Four-byte attributes, default 0006h, 31:16 zero
// [R4] Deep sleep value valid only with bit 4
// [R5] Baseline sleep value valid only with bit 3
// [R6] Alternate definitions bit implies LPM bit set
// [R7] LPM bit reads one, bit 0 zero
// [R8] Store programmer keeps LPM bit equal flag
// [R9] SuperSpeed header bytes 0Ah/10h/03h
// [R10] SuperSpeed attribute byte at 03h, default 00h
// [R11] Only latency message bit 1 survives, rest zero
// [R12] Speeds field at 04h, default 000Eh
// [R13] Multi-byte fields go least significant first
`timescale 1ns/1ps
`default_nettype none
module bcdb_builder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic cfg_load_done,
    input wire bcdb_pkg::bcdb_store_t store_i,
    input wire logic link_power_mgmt_capable_flag,
    input wire bcdb_pkg::bcdb_desc_req_t desc_req_i,
    output bcdb_pkg::bcdb_desc_ans_t desc_ans_o,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import bcdb_pkg::*;

    bcdb_state_t st_q;
    logic use_def_q;
    logic from_store_q;
    logic lpm_mismatch_q;
    logic [31:0] usb2_attr_q;
    logic [7:0] ss_attr_q;
    logic [15:0] ss_speeds_q;
    logic [31:0] usb2_attr_d;
    logic [7:0] ss_attr_d;
    logic [15:0] ss_speeds_d;
    logic use_store;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_full_q;
    logic w_full_q;
    logic wr_fire;
    logic wr_hit;
    logic rebuild;
    logic [31:0] rd_mux;
    logic rd_hit;

    // Stored image wins unless software asked for the built-in defaults
    assign use_store = store_i.present & !use_def_q; // [R1]

    // Attribute fields: pick source, clear reserved bits, force LPM
    bcdb_field_fix #(
        .W(32),
        .DEFAULT(USB2_ATTR_DEF),
        .KEEP(USB2_ATTR_KEEP),
        .SET(USB2_ATTR_SET)
    ) u_usb2_attr (
        .use_store(use_store),
        .stored(store_i.usb2_attr),
        .fixed(usb2_attr_d)
    );

    bcdb_field_fix #(
        .W(8),
        .DEFAULT(SS_ATTR_DEF),
        .KEEP(SS_ATTR_KEEP),
        .SET(SS_ATTR_SET)
    ) u_ss_attr (
        .use_store(use_store),
        .stored(store_i.ss_attr),
        .fixed(ss_attr_d)
    );

    bcdb_field_fix #(
        .W(16),
        .DEFAULT(SPEEDS_DEF),
        .KEEP(SPEEDS_KEEP),
        .SET(SPEEDS_SET)
    ) u_ss_speeds (
        .use_store(use_store),
        .stored(store_i.ss_speeds),
        .fixed(ss_speeds_d)
    );

    // Build sequence: wait for the store load, build, serve; a software rebuild request while serving builds again if cfg_load_done is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_WAIT;
        end else if (ce) begin
            case (st_q)
                ST_WAIT: begin
                    if (cfg_load_done) begin
                        st_q <= ST_BUILD;
                    end
                end
                ST_BUILD: st_q <= ST_READY;
                ST_READY: begin
                    if (rebuild && cfg_load_done) begin
                        st_q <= ST_BUILD;
                    end
                end
                default: st_q <= ST_WAIT;
            endcase
        end
    end

    // Capture the sanitised fields; the LPM bit is forced, so bit 2 can never stand alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb2_attr_q <= USB2_ATTR_DEF;
            ss_attr_q <= SS_ATTR_DEF;
            ss_speeds_q <= SPEEDS_DEF;
            from_store_q <= 1'b0;
            lpm_mismatch_q <= 1'b0;
        end else if (ce && st_q == ST_BUILD) begin
            usb2_attr_q <= usb2_attr_d; // [R3] [R4] [R5] [R6] [R7]
            ss_attr_q <= ss_attr_d; // [R10] [R11]
            ss_speeds_q <= ss_speeds_d; // [R12]
            from_store_q <= use_store;
            // Flags a store image that breaks the LPM agreement
            lpm_mismatch_q <= use_store &&
                (store_i.usb2_attr[ATTR_LPM_BIT] != link_power_mgmt_capable_flag); // [R8]
        end
    end

    // Descriptor byte server for the host controller
    bcdb_desc_port u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ready(st_q == ST_READY),
        .usb2_attr(usb2_attr_q),
        .ss_attr(ss_attr_q),
        .ss_speeds(ss_speeds_q),
        .req(desc_req_i),
        .ans(desc_ans_o)
    );

    // Write path: address and data are taken in either order, then one response
    assign wr_fire = aw_full_q & w_full_q & ~bvalid;
    assign wr_hit = (awaddr_q[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) ||
                    (awaddr_q[AXI_AW-1:2] == REG_STATUS[AXI_AW-1:2]) ||
                    (awaddr_q[AXI_AW-1:2] == REG_USB2_ATTR[AXI_AW-1:2]) ||
                    (awaddr_q[AXI_AW-1:2] == REG_SS_CAP[AXI_AW-1:2]);
    assign rebuild = wr_fire && wstrb_q[0] && wdata_q[CTRL_REBUILD_BIT] &&
                     awaddr_q[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                awaddr_q <= awaddr;
                aw_full_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_full_q <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            // Channels reopen only after the response, so one write at a time
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Software control bit; read-only registers ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            use_def_q <= 1'b0;
        end else if (ce && wr_fire && wstrb_q[0] &&
                     awaddr_q[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
            use_def_q <= wdata_q[CTRL_USE_DEF_BIT];
        end
    end

    // Read mux
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (araddr[AXI_AW-1:2])
            REG_CTRL[AXI_AW-1:2]: rd_mux[CTRL_USE_DEF_BIT] = use_def_q;
            REG_STATUS[AXI_AW-1:2]: begin
                rd_mux[STAT_READY_BIT] = (st_q == ST_READY);
                rd_mux[STAT_FROM_STORE_BIT] = from_store_q;
                rd_mux[STAT_LPM_MISMATCH_BIT] = lpm_mismatch_q;
                rd_mux[STAT_BUSY_BIT] = (st_q == ST_BUILD);
            end
            REG_USB2_ATTR[AXI_AW-1:2]: rd_mux = usb2_attr_q;
            REG_SS_CAP[AXI_AW-1:2]: begin
                rd_mux[7:0] = ss_attr_q;
                rd_mux[SS_CAP_SPEEDS_LSB +: 16] = ss_speeds_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read path: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_default_build: assert property ( // [R1]
        st_q == ST_BUILD && ce && !use_store
        |=> usb2_attr_q == USB2_ATTR_DEF && st_q == ST_READY)
        else $error("usb2 attributes not defaulted");
    a_attr_reserved: assert property ( // [R3]
        st_q == ST_READY |-> usb2_attr_q[31:16] == 16'h0000 && !usb2_attr_q[0])
        else $error("usb2 reserved attribute bits set");
    a_sleep_fields: assert property ( // [R4] [R5]
        st_q == ST_BUILD && ce && use_store
        |=> usb2_attr_q[15:8] == $past(store_i.usb2_attr[15:8])
            && usb2_attr_q[ATTR_DEEP_VALID_BIT] == $past(store_i.usb2_attr[ATTR_DEEP_VALID_BIT])
            && usb2_attr_q[ATTR_BASE_VALID_BIT] == $past(store_i.usb2_attr[ATTR_BASE_VALID_BIT]))
        else $error("sleep latency fields not carried");
    a_alt_needs_lpm: assert property ( // [R6]
        usb2_attr_q[ATTR_ALT_BIT] |-> usb2_attr_q[ATTR_LPM_BIT])
        else $error("alternate bit without lpm bit");
    a_lpm_forced: assert property ( // [R7]
        st_q == ST_BUILD && ce |=> usb2_attr_q[ATTR_LPM_BIT] ##1 usb2_attr_q[ATTR_LPM_BIT])
        else $error("lpm bit not one");
    a_ss_reserved: assert property ( // [R11]
        (ss_attr_q & ~SS_ATTR_KEEP) == 8'h00 && (ss_speeds_q & ~SPEEDS_KEEP) == 16'h0000)
        else $error("ss reserved bits set");
    a_ss_defaults: assert property ( // [R10]
        st_q == ST_BUILD && ce && !use_store
        |=> ss_attr_q == SS_ATTR_DEF && ss_speeds_q == SPEEDS_DEF)
        else $error("ss fields not defaulted");
    a_speeds_store: assert property ( // [R12]
        st_q == ST_BUILD && ce && use_store
        |=> ss_speeds_q == ($past(store_i.ss_speeds) & SPEEDS_KEEP))
        else $error("speeds field not loaded");
    a_read_answer: assert property (
        arvalid && arready && ce |=> rvalid && !arready)
        else $error("read not answered next cycle");
    a_mismatch_flag: assert property ( // [R8]
        st_q == ST_BUILD && ce && use_store
        && (store_i.usb2_attr[ATTR_LPM_BIT] != link_power_mgmt_capable_flag) |=> lpm_mismatch_q)
        else $error("lpm mismatch not flagged");

    c_from_store: cover property (st_q == ST_BUILD && ce && use_store);
    c_from_default: cover property (st_q == ST_BUILD && ce && !use_store);
    c_rebuild: cover property (rebuild && st_q == ST_READY);
    c_write_done: cover property (bvalid && bready && bresp == RESP_OKAY);
endmodule // bcdb_builder
`default_nettype wire

// [verilog/bcdb_desc_port.sv]
// Byte read port that serves the two built capability descriptors
`timescale 1ns/1ps
`default_nettype none
module bcdb_desc_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic ready,
    input wire logic [31:0] usb2_attr,
    input wire logic [7:0] ss_attr,
    input wire logic [15:0] ss_speeds,
    input wire bcdb_pkg::bcdb_desc_req_t req,
    output bcdb_pkg::bcdb_desc_ans_t ans
);
    import bcdb_pkg::*;

    logic [7:0] byte_d;
    logic err_d;

    // Byte mux; multi-byte fields go out least significant byte first
    always_comb begin
        byte_d = 8'h00;
        err_d = !ready;
        if (req.sel == SEL_USB2) begin
            case (req.off)
                OFF_LEN: byte_d = USB2_LEN; // [R2]
                OFF_TYPE: byte_d = CAP_DESC_TYPE; // [R2]
                OFF_CAP: byte_d = USB2_CAP_TYPE; // [R2]
                default: begin
                    if (req.off >= OFF_ATTR && req.off < USB2_LEN[3:0]) begin
                        byte_d = usb2_attr[8*(req.off - OFF_ATTR) +: 8]; // [R13]
                    end else begin
                        err_d = 1'b1;
                    end
                end
            endcase
        end else begin
            case (req.off)
                OFF_LEN: byte_d = SS_LEN; // [R9]
                OFF_TYPE: byte_d = CAP_DESC_TYPE; // [R9]
                OFF_CAP: byte_d = SS_CAP_TYPE; // [R9]
                OFF_ATTR: byte_d = ss_attr;
                OFF_SPEEDS: byte_d = ss_speeds[7:0]; // [R13]
                OFF_SPEEDS_HI: byte_d = ss_speeds[15:8];
                default: err_d = err_d | (req.off >= SS_LEN[3:0]); // Offsets 6 to 9 read as zero, offsets past the end are refused
            endcase
        end
    end

    // One answer per request, one cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ans <= '0;
        end else if (ce) begin
            ans.valid <= req.valid;
            ans.err <= req.valid & err_d;
            // Refused requests carry zero data so a host never mistakes them for a header
            ans.data <= (req.valid && !err_d) ? byte_d : 8'h00;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_usb2_header: assert property ( // [R2]
        req.valid && ce && ready && req.sel == SEL_USB2 && req.off == OFF_LEN
        |=> ans.valid && !ans.err && ans.data == USB2_LEN)
        else $error("usb2 length byte wrong");
    a_ss_header: assert property ( // [R9]
        req.valid && ce && ready && req.sel == SEL_SS && req.off == OFF_CAP
        |=> ans.valid && ans.data == SS_CAP_TYPE)
        else $error("ss capability type byte wrong");
    a_lsb_first: assert property ( // [R13]
        req.valid && ce && ready && req.sel == SEL_USB2 && req.off == OFF_ATTR
        |=> ans.data == $past(usb2_attr[7:0]))
        else $error("attribute not least significant byte first");
    a_not_ready: assert property (
        req.valid && ce && !ready |=> ans.valid && ans.err && ans.data == 8'h00)
        else $error("read before build not refused");
    c_ss_speeds: cover property (req.valid && ce && ready && req.off == OFF_SPEEDS);
endmodule // bcdb_desc_port
`default_nettype wire

// [verilog/bcdb_field_fix.sv]
// Selects stored or default field value and forces reserved and fixed bits
`timescale 1ns/1ps
`default_nettype none
module bcdb_field_fix #(
    parameter int W = 8,
    parameter logic [W-1:0] DEFAULT = '0,
    parameter logic [W-1:0] KEEP = '1,
    parameter logic [W-1:0] SET = '0
) (
    input wire logic use_store,
    input wire logic [W-1:0] stored,
    output logic [W-1:0] fixed
);
    // Reserved bits drop to zero, mandatory bits rise to one
    assign fixed = ((use_store ? stored : DEFAULT) & KEEP) | SET;
endmodule // bcdb_field_fix
`default_nettype wire
